// ---- hdl/gesl_top.sv ----
// Event source logic of one camera and illumination controller module: edge detect,
// cause encode, occurrence counters, event queue and AXI4-Lite register slave.
// Assumes all event inputs are synchronous one-cycle pulses or levels on aclk.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module gesl_top #(
	parameter int unsigned QDEPTH = 16
) (
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_awaddr,
	input  wire logic               s_awvalid,
	output logic                    s_awready,
	input  wire logic [31:0]        s_wdata,
	input  wire logic [3:0]         s_wstrb,
	input  wire logic               s_wvalid,
	output logic                    s_wready,
	output logic [1:0]              s_bresp,
	output logic                    s_bvalid,
	input  wire logic               s_bready,
	input  wire logic [7:0]         s_araddr,
	input  wire logic               s_arvalid,
	output logic                    s_arready,
	output logic [31:0]             s_rdata,
	output logic [1:0]              s_rresp,
	output logic                    s_rvalid,
	input  wire logic               s_rready,
	// Controller signals
	input  wire logic               cam_trig,
	input  wire logic               strobe,
	input  wire logic               allow_next,
	input  wire logic               discard_p,
	input  wire logic               pending_p,
	input  wire logic               trig_ack_p,
	input  wire logic               resend_p,
	// Data stream and link
	input  wire logic               sos_p,
	input  wire logic               eos_p,
	input  wire logic               reject_p,
	input  wire gesl_pkg::gesl_cause_s cause,
	input  wire logic [3:0]         crc_err_p,
	// Context sources
	input  wire logic [31:0]        io_lines,
	input  wire logic [31:0]        qpos,
	// Interrupt
	output logic                    irq
);
	localparam int unsigned AW = $clog2(QDEPTH);
	localparam int unsigned N = gesl_pkg::NSRC;

	// Edge detect
	logic cam_d_r;
	logic stb_d_r;
	logic allow_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cam_d_r <= 1'b0;
			stb_d_r <= 1'b0;
			allow_d_r <= 1'b0;
		end else begin
			cam_d_r <= cam_trig;
			stb_d_r <= strobe;
			allow_d_r <= allow_next;
		end
	end

	logic [N-1:0]  ev;
	logic [31:0]   cause_w [N];
	always_comb begin
		ev = '0;
		for (int i = 0; i < N; i++) cause_w[i] = 32'h0000_0000;
		ev[gesl_pkg::SRC_CAM_RISE] = cam_trig & ~cam_d_r;
		ev[gesl_pkg::SRC_CAM_FALL] = ~cam_trig & cam_d_r;
		ev[gesl_pkg::SRC_STB_RISE] = strobe & ~stb_d_r;
		ev[gesl_pkg::SRC_STB_FALL] = ~strobe & stb_d_r;
		ev[gesl_pkg::SRC_ALLOW] = allow_next & ~allow_d_r;
		ev[gesl_pkg::SRC_DISCARD] = discard_p;
		ev[gesl_pkg::SRC_PENDING] = pending_p;
		ev[gesl_pkg::SRC_TRIG_ACK] = trig_ack_p;
		ev[gesl_pkg::SRC_RESEND] = resend_p;
		ev[gesl_pkg::SRC_SOS] = sos_p;
		ev[gesl_pkg::SRC_EOS] = eos_p;
		ev[gesl_pkg::SRC_REJECT] = reject_p;
		ev[gesl_pkg::SRC_CRC_A +: 4] = crc_err_p;
		// Only defined bits pass; the rest read zero
		cause_w[gesl_pkg::SRC_DISCARD] = {28'h0, cause.discard} & gesl_pkg::CAUSE_DISCARD_M;
		cause_w[gesl_pkg::SRC_PENDING] = {30'h0, cause.pending} & gesl_pkg::CAUSE_PENDING_M;
		cause_w[gesl_pkg::SRC_SOS] = {28'h0, cause.sos} & gesl_pkg::CAUSE_SOS_M;
		cause_w[gesl_pkg::SRC_EOS] = {26'h0, cause.eos} & gesl_pkg::CAUSE_EOS_M;
		cause_w[gesl_pkg::SRC_REJECT] = {30'h0, cause.reject} & gesl_pkg::CAUSE_REJECT_M;
	end

	// Microsecond time stamp
	logic [7:0]  us_div_r;
	logic [31:0] stamp_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			us_div_r <= 8'h00;
			stamp_r <= 32'h0000_0000;
		end else if (us_div_r == 8'(gesl_pkg::US_CYC - 1)) begin
			us_div_r <= 8'h00;
			stamp_r <= stamp_r + 32'h0000_0001;
		end else begin
			us_div_r <= us_div_r + 8'h01;
		end
	end

	// Software registers
	logic [31:0] notify_en_r;
	logic [1:0]  irq_mask_r;
	logic [1:0]  irq_stat_r;
	logic [3:0]  cnt_sel_r;
	logic [5:0]  ctx_cfg_r;
	logic        clr_one;
	logic        clr_all;
	logic        pop;
	logic        wr_go;
	logic [7:0]  wa;

	// Occurrence counters, never gated by the notify filter
	logic [31:0] cnt_r [N];
	for (genvar g = 0; g < N; g++) begin : g_cnt
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt_r[g] <= 32'h0000_0000;
			end else if (clr_all || (clr_one && cnt_sel_r == 4'(g))) begin
				cnt_r[g] <= ev[g] ? 32'h0000_0001 : 32'h0000_0000;
			end else if (ev[g]) begin
				cnt_r[g] <= cnt_r[g] + 32'h0000_0001;
			end
		end
	end

	// Lowest notified source wins per cycle; simultaneous others are counted only
	logic [3:0]  win;
	logic        win_v;
	always_comb begin
		win = 4'h0;
		win_v = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (ev[i] && notify_en_r[i]) begin
				win = 4'(i);
				win_v = 1'b1;
			end
		end
	end

	function automatic logic [31:0] ctx_pick(input logic [1:0] s, input logic [31:0] c, input logic [31:0] k,
			input logic [31:0] io, input logic [31:0] q);
		case (s)
			gesl_pkg::CTX_CAUSE: ctx_pick = c;
			gesl_pkg::CTX_IO: ctx_pick = io;
			gesl_pkg::CTX_COUNT: ctx_pick = k;
			default: ctx_pick = q;
		endcase
	endfunction

	// Event queue
	gesl_pkg::gesl_entry_s q_mem [QDEPTH];
	logic [AW:0]   wp_r;
	logic [AW:0]   rp_r;
	logic          q_empty;
	logic          q_full;
	logic          push;
	logic [AW:0]   q_lvl;
	logic [31:0]   cnt_ev;
	assign q_empty = (wp_r == rp_r);
	assign q_full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign push = win_v && !q_full;
	// Level kept at pointer width so a wrapped difference stays correct
	assign q_lvl = wp_r - rp_r;
	assign cnt_ev = (clr_all || (clr_one && cnt_sel_r == win)) ? 32'h0000_0001 : cnt_r[win] + 32'h0000_0001;
	always_ff @(posedge aclk) begin
		if (push) begin
			q_mem[wp_r[AW-1:0]] <= '{src: win, stamp: stamp_r,
				ctx0: ctx_pick(ctx_cfg_r[1:0], cause_w[win], cnt_ev, io_lines, qpos),
				ctx1: ctx_pick(ctx_cfg_r[3:2], cause_w[win], cnt_ev, io_lines, qpos),
				ctx2: ctx_pick(ctx_cfg_r[5:4], cause_w[win], cnt_ev, io_lines, qpos)};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop && !q_empty) rp_r <= rp_r + 1'b1;
		end
	end
	gesl_pkg::gesl_entry_s head;
	assign head = q_mem[rp_r[AW-1:0]];

	// AXI4-Lite write path
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	assign wr_go = aw_got_r && w_got_r && !s_bvalid;
	assign wa = awaddr_r;
	assign clr_one = wr_go && wa == gesl_pkg::OFS_CTRL && wdata_r[gesl_pkg::CTRL_CLR_ONE];
	assign clr_all = wr_go && wa == gesl_pkg::OFS_CTRL && wdata_r[gesl_pkg::CTRL_CLR_ALL];
	assign pop = wr_go && wa == gesl_pkg::OFS_POP;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= gesl_pkg::RESP_OKAY;
		end else begin
			s_awready <= !aw_got_r && !s_awready && s_awvalid;
			s_wready <= !w_got_r && !s_wready && s_wvalid;
			if (s_awvalid && s_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_wdata;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (wa > gesl_pkg::OFS_CTX_CFG || wa[1:0] != 2'h0) ? gesl_pkg::RESP_SLVERR
					: gesl_pkg::RESP_OKAY;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers; s_wstrb is ignored, so every write loads the whole register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			notify_en_r <= gesl_pkg::NOTIFY_EN_RST;
			irq_mask_r <= 2'h0;
			cnt_sel_r <= 4'h0;
			ctx_cfg_r <= 6'h00;
		end else if (wr_go) begin
			case (wa)
				gesl_pkg::OFS_NOTIFY_EN: notify_en_r <= wdata_r;
				gesl_pkg::OFS_IRQ_MASK: irq_mask_r <= wdata_r[1:0];
				gesl_pkg::OFS_CNT_SEL: cnt_sel_r <= wdata_r[3:0];
				gesl_pkg::OFS_CTX_CFG: ctx_cfg_r <= wdata_r[5:0];
				default: ;
			endcase
		end
	end

	// Read path
	logic rd_stat;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= gesl_pkg::RESP_OKAY;
		end else begin
			s_arready <= !s_arready && !s_rvalid && s_arvalid;
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= gesl_pkg::RESP_OKAY;
				case (s_araddr)
					gesl_pkg::OFS_CTRL: s_rdata <= 32'h0000_0000;
					gesl_pkg::OFS_NOTIFY_EN: s_rdata <= notify_en_r;
					gesl_pkg::OFS_QSTAT: s_rdata <= {23'h0, q_full, 7'(q_lvl), !q_empty};
					gesl_pkg::OFS_POP: s_rdata <= 32'h0000_0000;
					gesl_pkg::OFS_E_SRC: s_rdata <= {28'h0, head.src};
					gesl_pkg::OFS_E_TIME: s_rdata <= head.stamp;
					gesl_pkg::OFS_E_CTX0: s_rdata <= head.ctx0;
					gesl_pkg::OFS_E_CTX1: s_rdata <= head.ctx1;
					gesl_pkg::OFS_E_CTX2: s_rdata <= head.ctx2;
					gesl_pkg::OFS_IRQ_STAT: s_rdata <= {30'h0, irq_stat_r};
					gesl_pkg::OFS_IRQ_MASK: s_rdata <= {30'h0, irq_mask_r};
					gesl_pkg::OFS_CNT_SEL: s_rdata <= {28'h0, cnt_sel_r};
					gesl_pkg::OFS_CNT_VAL: s_rdata <= cnt_r[cnt_sel_r];
					gesl_pkg::OFS_CTX_CFG: s_rdata <= {26'h0, ctx_cfg_r};
					default: begin
						s_rdata <= 32'h0000_0000;
						s_rresp <= gesl_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end
	assign rd_stat = s_arvalid && s_arready && s_araddr == gesl_pkg::OFS_IRQ_STAT;

	// Sticky status, cleared by read; a new event in the same cycle wins
	logic [1:0] irq_set;
	assign irq_set = {win_v && q_full, push};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r) | irq_set;
			irq <= |((irq_stat_r | irq_set) & irq_mask_r) || (!q_empty && irq_mask_r[gesl_pkg::IRQ_NONEMPTY]);
		end
	end

	// Assertions
	a_cam_rise_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(cam_trig && !cam_d_r && !clr_all && !clr_one) |=> cnt_r[0] == $past(cnt_r[0]) + 32'h0000_0001)
		else $error("camera rise not counted");
	a_cam_fall_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(!cam_trig && cam_d_r && !clr_all && !clr_one) |=> cnt_r[1] == $past(cnt_r[1]) + 32'h0000_0001)
		else $error("camera fall not counted");
	a_strobe_events: assert property (@(posedge aclk) disable iff (!aresetn)
		(strobe && !stb_d_r && !clr_all && !clr_one) |=> cnt_r[2] == $past(cnt_r[2]) + 32'h0000_0001)
		else $error("strobe rise not counted");
	a_clear_all: assert property (@(posedge aclk) disable iff (!aresetn)
		clr_all |=> cnt_r[3] <= 32'h0000_0001)
		else $error("clear all failed");
	a_notify_reset: assert property (@(posedge aclk)
		!aresetn |=> notify_en_r == 32'h0000_0000)
		else $error("notify not disabled by reset");
	a_no_notify_push: assert property (@(posedge aclk) disable iff (!aresetn)
		(notify_en_r == 32'h0000_0000) |-> !push)
		else $error("push while all disabled");
	a_pop_drains: assert property (@(posedge aclk) disable iff (!aresetn)
		(pop && !q_empty && !push) |=> q_lvl == $past(q_lvl) - 1'b1)
		else $error("pop did not remove entry");
	a_eos_undef_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		cause_w[gesl_pkg::SRC_EOS][0] == 1'b0 && cause_w[gesl_pkg::SRC_SOS][0] == 1'b0)
		else $error("undefined cause bit set");
	a_crc_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(crc_err_p[2] && !clr_all && !clr_one) |=> cnt_r[14] == $past(cnt_r[14]) + 32'h0000_0001)
		else $error("crc C not counted");
	a_irq_empty: assert property (@(posedge aclk) disable iff (!aresetn)
		(q_empty && irq_stat_r == 2'h0 && irq_set == 2'h0) |=> !irq)
		else $error("irq without cause");
	c_push: cover property (@(posedge aclk) disable iff (!aresetn) push);
	c_full: cover property (@(posedge aclk) disable iff (!aresetn) q_full);
	c_pop: cover property (@(posedge aclk) disable iff (!aresetn) pop && !q_empty);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule // gesl_top
`default_nettype wire

// ---- common/gesl_pkg.sv ----
// Package for the grabber event source logic: register map, source ids, cause bits.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz clock.
package gesl_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned NSRC = 16;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_NOTIFY_EN = 8'h04;
	localparam logic [7:0] OFS_QSTAT = 8'h08;
	localparam logic [7:0] OFS_POP = 8'h0C;
	localparam logic [7:0] OFS_E_SRC = 8'h10;
	localparam logic [7:0] OFS_E_TIME = 8'h14;
	localparam logic [7:0] OFS_E_CTX0 = 8'h18;
	localparam logic [7:0] OFS_E_CTX1 = 8'h1C;
	localparam logic [7:0] OFS_E_CTX2 = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFS_CNT_SEL = 8'h2C;
	localparam logic [7:0] OFS_CNT_VAL = 8'h30;
	localparam logic [7:0] OFS_CTX_CFG = 8'h34;
	// Control bit positions
	localparam int unsigned CTRL_CLR_ONE = 0;
	localparam int unsigned CTRL_CLR_ALL = 1;
	// Irq status bits
	localparam int unsigned IRQ_NONEMPTY = 0;
	localparam int unsigned IRQ_OVERFLOW = 1;
	localparam logic [31:0] NOTIFY_EN_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Source identifiers
	localparam logic [3:0] SRC_CAM_RISE = 4'h0;
	localparam logic [3:0] SRC_CAM_FALL = 4'h1;
	localparam logic [3:0] SRC_STB_RISE = 4'h2;
	localparam logic [3:0] SRC_STB_FALL = 4'h3;
	localparam logic [3:0] SRC_ALLOW = 4'h4;
	localparam logic [3:0] SRC_DISCARD = 4'h5;
	localparam logic [3:0] SRC_PENDING = 4'h6;
	localparam logic [3:0] SRC_TRIG_ACK = 4'h7;
	localparam logic [3:0] SRC_RESEND = 4'h8;
	localparam logic [3:0] SRC_SOS = 4'h9;
	localparam logic [3:0] SRC_EOS = 4'hA;
	localparam logic [3:0] SRC_REJECT = 4'hB;
	localparam logic [3:0] SRC_CRC_A = 4'hC;
	// Cause masks of defined bits per source
	localparam logic [31:0] CAUSE_DISCARD_M = 32'h0000_000F;
	localparam logic [31:0] CAUSE_PENDING_M = 32'h0000_0003;
	localparam logic [31:0] CAUSE_SOS_M = 32'h0000_000E;
	localparam logic [31:0] CAUSE_EOS_M = 32'h0000_003E;
	localparam logic [31:0] CAUSE_REJECT_M = 32'h0000_0003;
	// Context word selectors
	localparam logic [1:0] CTX_CAUSE = 2'h0;
	localparam logic [1:0] CTX_IO = 2'h1;
	localparam logic [1:0] CTX_COUNT = 2'h2;
	localparam logic [1:0] CTX_POS = 2'h3;

	typedef struct packed {
		logic [3:0]  src;
		logic [31:0] stamp;
		logic [31:0] ctx0;
		logic [31:0] ctx1;
		logic [31:0] ctx2;
	} gesl_entry_s;

	typedef struct packed {
		logic [5:0] eos;
		logic [3:0] sos;
		logic [3:0] discard;
		logic [1:0] pending;
		logic [1:0] reject;
	} gesl_cause_s;
endpackage

// ---- tb/gesl_partner.sv ----
// Model of the controller, stream and link side: edges, pulses, causes and context.
// Assumes one fire call at a time from the bench; all changes just after aclk rises.
`timescale 1ns/1ns
`default_nettype none
module gesl_partner (
	// Clock
	input  wire logic                  aclk,
	// Levels and pulses
	output logic                       cam_trig,
	output logic                       strobe,
	output logic                       allow_next,
	output logic [6:0]                 pulse,
	output logic [3:0]                 crc_err_p,
	// Cause and context
	output gesl_pkg::gesl_cause_s      cause,
	output logic [31:0]                io_lines,
	output logic [31:0]                qpos
);
	initial begin
		cam_trig = 1'b0;
		strobe = 1'b0;
		allow_next = 1'b0;
		pulse = 7'h00;
		crc_err_p = 4'h0;
		cause = '0;
		io_lines = 32'h0;
		qpos = 32'h0;
	end

	task automatic fire(input int id, input logic [17:0] cz, input logic [31:0] io);
		@(posedge aclk);
		io_lines <= io;
		qpos <= ~io;
		cause <= cz;
		case (id)
			0: cam_trig <= 1'b1;
			1: cam_trig <= 1'b0;
			2: strobe <= 1'b1;
			3: strobe <= 1'b0;
			4: allow_next <= 1'b1;
			default: begin
				if (id < 12) pulse[id-5] <= 1'b1;
				else crc_err_p[id-12] <= 1'b1;
			end
		endcase
		@(posedge aclk);
		pulse <= 7'h00;
		crc_err_p <= 4'h0;
		allow_next <= 1'b0;
		// Cause is only valid with its pulse
		cause <= ~cz;
		@(posedge aclk);
		io_lines <= ~io;
	endtask
endmodule // gesl_partner
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: AXI4-Lite master, event partner, queued bus expectations.
// Assumes the design answers every bus request within 50 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb;
	typedef struct packed {logic wr; logic [31:0] d; logic [1:0] r;} gesl_exp_s;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [7:0]            awaddr = 8'h00;
	logic [7:0]            araddr = 8'h00;
	logic [31:0]           wdata = 32'h0;
	logic                  awvalid = 1'b0;
	logic                  wvalid = 1'b0;
	logic                  bready = 1'b0;
	logic                  arvalid = 1'b0;
	logic                  rready = 1'b0;
	logic                  awready, wready, bvalid, arready, rvalid, irq, cam_trig, strobe, allow_next;
	logic [1:0]            bresp, rresp;
	logic [31:0]           rdata, io_lines, qpos, io;
	logic [6:0]            pulse;
	logic [3:0]            crc_err_p;
	logic [17:0]           cz;
	logic [31:0]           iov [5];
	gesl_pkg::gesl_cause_s cause;
	gesl_exp_s             exq[$];
	gesl_exp_s             e;
	int                    fails = 0;
	int                    checks_done = 0;
	localparam logic [1:0] OK = gesl_pkg::RESP_OKAY;

	always #50 aclk = ~aclk;

	gesl_partner p (.aclk(aclk), .cam_trig(cam_trig), .strobe(strobe), .allow_next(allow_next), .pulse(pulse),
		.crc_err_p(crc_err_p), .cause(cause), .io_lines(io_lines), .qpos(qpos));

	gesl_top #(.QDEPTH(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.cam_trig(cam_trig), .strobe(strobe), .allow_next(allow_next), .discard_p(pulse[0]),
		.pending_p(pulse[1]), .trig_ack_p(pulse[2]), .resend_p(pulse[3]), .sos_p(pulse[4]), .eos_p(pulse[5]),
		.reject_p(pulse[6]), .cause(cause), .crc_err_p(crc_err_p), .io_lines(io_lines), .qpos(qpos), .irq(irq));

	task automatic report_and_stop();
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus results are matched against the oldest note
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (exq.size() == 0) begin
				fails++;
				$display("ERROR %0t: response without request", $time);
			end else begin
				e = exq.pop_front();
				if (e.wr) cmp({32'h0, bresp}, {32'h0, e.r});
				else cmp({rdata, rresp}, {e.d, e.r});
			end
		end
	end

	task automatic timeout_chk(input int n);
		if (n >= 50) begin
			fails++;
			$display("ERROR %0t: bus wait timed out", $time);
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		exq.push_back('{wr: 1'b1, d: 32'h0, r: er});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 50);
		bready <= 1'b0;
		timeout_chk(n);
		// One edge apart, so a following call never reassigns bready in this step
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		exq.push_back('{wr: 1'b0, d: ed, r: er});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 50);
		rready <= 1'b0;
		timeout_chk(n);
		@(posedge aclk);
	endtask

	// Registered level: give it a few cycles to settle
	task automatic chk_irq(input logic ei);
		int n;
		n = 0;
		while (irq !== ei && n < 4) begin
			@(posedge aclk);
			n++;
		end
		cmp({33'h0, irq}, {33'h0, ei});
	endtask

	function automatic logic [31:0] exp_cause(input int id, input logic [17:0] c);
		gesl_pkg::gesl_cause_s s;
		s = c;
		case (id)
			5: return {28'h0, s.discard};
			6: return {30'h0, s.pending};
			9: return {28'h0, s.sos & 4'hE};
			10: return {26'h0, s.eos & 6'h3E};
			11: return {30'h0, s.reject};
			default: return 32'h0;
		endcase
	endfunction

	initial begin
		void'($urandom(78322));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_irq(1'b0);
		rd(gesl_pkg::OFS_NOTIFY_EN, 32'h0, OK);
		rd(gesl_pkg::OFS_QSTAT, 32'h0, OK);
		rd(8'h3C, 32'h0, gesl_pkg::RESP_SLVERR);
		wr(8'h38, 32'h0, gesl_pkg::RESP_SLVERR);
		wr(gesl_pkg::OFS_NOTIFY_EN, 32'h0000_FFFF, OK);
		wr(gesl_pkg::OFS_CTX_CFG, 32'h0000_0024, OK);
		wr(gesl_pkg::OFS_IRQ_MASK, 32'h0000_0001, OK);
		for (int id = 0; id < 16; id++) begin
			cz = 18'($urandom);
			io = $urandom;
			p.fire(id, cz, io);
			chk_irq(1'b1);
			rd(gesl_pkg::OFS_QSTAT, 32'h0000_0003, OK);
			rd(gesl_pkg::OFS_E_SRC, 32'(id), OK);
			rd(gesl_pkg::OFS_E_CTX0, exp_cause(id, cz), OK);
			rd(gesl_pkg::OFS_E_CTX1, io, OK);
			rd(gesl_pkg::OFS_E_CTX2, 32'h0000_0001, OK);
			rd(gesl_pkg::OFS_IRQ_STAT, 32'h0000_0001, OK);
			wr(gesl_pkg::OFS_POP, 32'h0, OK);
			rd(gesl_pkg::OFS_QSTAT, 32'h0, OK);
			chk_irq(1'b0);
		end
		// Overflow a four-deep queue with the interrupt masked
		wr(gesl_pkg::OFS_IRQ_MASK, 32'h0, OK);
		wr(gesl_pkg::OFS_CTX_CFG, 32'h0000_0027, OK);
		for (int k = 0; k < 5; k++) begin
			iov[k] = $urandom;
			p.fire(k < 4 ? 12 + k : 11, 18'($urandom), iov[k]);
		end
		chk_irq(1'b0);
		rd(gesl_pkg::OFS_QSTAT, 32'h0000_0109, OK);
		wr(gesl_pkg::OFS_IRQ_MASK, 32'h0000_0002, OK);
		chk_irq(1'b1);
		rd(gesl_pkg::OFS_IRQ_STAT, 32'h0000_0003, OK);
		chk_irq(1'b0);
		for (int k = 0; k < 4; k++) begin
			rd(gesl_pkg::OFS_E_SRC, 32'(12 + k), OK);
			rd(gesl_pkg::OFS_E_CTX0, ~iov[k], OK);
			wr(gesl_pkg::OFS_POP, 32'h0, OK);
		end
		rd(gesl_pkg::OFS_QSTAT, 32'h0, OK);
		// Counters keep counting with notification off
		wr(gesl_pkg::OFS_CNT_SEL, 32'h0000_000C, OK);
		rd(gesl_pkg::OFS_CNT_VAL, 32'h0000_0002, OK);
		wr(gesl_pkg::OFS_NOTIFY_EN, 32'h0, OK);
		p.fire(12, 18'h0, 32'h0);
		rd(gesl_pkg::OFS_CNT_VAL, 32'h0000_0003, OK);
		rd(gesl_pkg::OFS_QSTAT, 32'h0, OK);
		wr(gesl_pkg::OFS_CTRL, 32'h0000_0001, OK);
		rd(gesl_pkg::OFS_CNT_VAL, 32'h0000_0000, OK);
		wr(gesl_pkg::OFS_CNT_SEL, 32'h0000_000D, OK);
		rd(gesl_pkg::OFS_CNT_VAL, 32'h0000_0002, OK);
		wr(gesl_pkg::OFS_CTRL, 32'h0000_0002, OK);
		rd(gesl_pkg::OFS_CNT_VAL, 32'h0000_0000, OK);
		repeat (2) @(posedge aclk);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
